// File: verif/ncap_host_properties.sv
// Pin checker for the host controller.
// Assumes it is bound into ncap_host.
`timescale 1ns/1ns
`default_nettype none
module ncap_host_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // Request port
   input wire logic       reqValid,
   input wire logic       reqReady,
   input wire logic [3:0] reqOp,
   input wire logic       opRejected,
   // Flash pins
   input wire logic [7:0] ioOut,
   input wire logic       ioOe_n,
   input wire logic       chipSelect_n,
   input wire logic       cmdLatch,
   input wire logic       addrLatch,
   input wire logic       writeStrobe_n,
   input wire logic       output_strobe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence wr_pulse;
      !writeStrobe_n[*2] ##1 writeStrobe_n;
   endsequence
   sequence rd_pulse;
      !output_strobe_n[*3] ##1 output_strobe_n;
   endsequence
   strobe_sel_a: assert property ($fell(writeStrobe_n) |-> !chipSelect_n)
      else $error("write strobe while deselected");
   strobe_shape_a: assert property ($fell(writeStrobe_n) |-> wr_pulse)
      else $error("write strobe width wrong");
   latch_stable_a: assert property (!writeStrobe_n ##1 writeStrobe_n |->
      $stable(ioOut) && $stable(cmdLatch) && $stable(addrLatch))
      else $error("byte or latch moved at strobe rise");
   bus_drive_a: assert property (!writeStrobe_n |-> !ioOe_n && !(cmdLatch && addrLatch))
      else $error("bus not driven during write");
   bus_release_a: assert property (!output_strobe_n |-> ioOe_n && !chipSelect_n)
      else $error("bus contention during read");
   read_pulse_a: assert property ($fell(output_strobe_n) |-> rd_pulse)
      else $error("read strobe width wrong");
   cmd_legal_a: assert property ($rose(writeStrobe_n) && cmdLatch |-> ioOut inside
      {8'h00, 8'h30, 8'h35, 8'h90, 8'hff, 8'h80, 8'h10, 8'h85, 8'h60, 8'hd0, 8'h05,
       8'he0, 8'h70, 8'h7a})
      else $error("undefined command code");
   unknown_reject_a: assert property (reqValid && reqReady && reqOp > 4'ha |=> opRejected)
      else $error("unknown op not rejected");
endmodule
bind ncap_host ncap_host_properties u_props (.clk(clk), .arst_n(arst_n),
   .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .opRejected(opRejected),
   .ioOut(ioOut), .ioOe_n(ioOe_n), .chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch),
   .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .output_strobe_n(output_strobe_n));
`default_nettype wire

// File: verif/ncap_host_tb.sv
// Bench for the host controller against the device model.
// Assumes the model answers on a resolved bus.
`timescale 1ns/1ns
`default_nettype none
module ncap_host_tb;
   localparam logic [7:0]  ID_B = 8'h3c; // Arbitrary value
   localparam logic [7:0]  ST_B = 8'he0;
   localparam logic [27:0] ADR  = 28'ha5c3740;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        reqValid = 1'b0;
   logic [3:0]  reqOp = 4'h0;
   logic [27:0] reqAddr = 28'h0;
   logic [12:0] reqLen = 13'h0;
   logic [7:0]  wrData = 8'h00;
   logic        wrValid = 1'b0;
   logic [7:0]  lastBus = 8'h00;
   logic [9:0]  expQ[$];
   logic [7:0]  rdQ[$];
   logic        rej;
   int          miscompares = 0;
   int          n_compared = 0;
   wire logic [7:0] ioOut, ioIn, rdData, devData;
   wire logic   reqReady, doneValid, opRejected, wrReady, rdValid, ioOe_n, chipSelect_n;
   wire logic   cmdLatch, addrLatch, writeStrobe_n, output_strobe_n, writeProtect_n, devOe, rbLow;
   always #5 clk = ~clk;
   // Undriven bus toggles every cycle
   assign ioIn = !ioOe_n ? ioOut : devOe ? devData : ~lastBus;
   always @(posedge clk) lastBus <= ioIn;
   always @(posedge clk) if (rdValid === 1'b1) rdQ.push_back(rdData);
   ncap_host u_dut (.clk(clk), .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady),
      .reqOp(reqOp), .reqAddr(reqAddr), .reqLen(reqLen), .doneValid(doneValid),
      .opRejected(opRejected), .wrData(wrData), .wrValid(wrValid), .wrReady(wrReady),
      .rdData(rdData), .rdValid(rdValid), .rdReady(1'b1), .ioOut(ioOut), .ioOe_n(ioOe_n),
      .ioIn(ioIn), .chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .writeStrobe_n(writeStrobe_n), .output_strobe_n(output_strobe_n),
      .writeProtect_n(writeProtect_n), .readyBusy(!rbLow));
   ncap_nand_model #(.ID_BYTE(ID_B), .ST_BYTE(ST_B)) u_mdl (.clk(clk), .ioOut(ioOut),
      .chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .writeStrobe_n(writeStrobe_n), .output_strobe_n(output_strobe_n),
      .writeProtect_n(writeProtect_n), .devData(devData), .devOe(devOe), .rbLow(rbLow));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic void e(input logic [1:0] k, input logic [7:0] b);
      expQ.push_back({k, b});
   endfunction
   function automatic void addr(input logic [27:0] a, input int s, input int c);
      logic [7:0] b[4];
      b = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20]};
      for (int j = s; j < s + c; j++) e(2'd2, b[j]);
   endfunction
   task automatic push(input logic [7:0] b);
      int i;
      i = 0;
      wrData = b;
      wrValid = 1'b1;
      while (wrReady !== 1'b1 && i++ < 20000) @(posedge clk) #1;
      if (i >= 20000) miscompares++;
      @(posedge clk) #1;
   endtask
   task automatic run(input logic [3:0] op, input logic [27:0] a, input logic [12:0] n);
      int i;
      i = 0;
      u_mdl.log.delete();
      rdQ.delete();
      reqOp = op;
      reqAddr = a;
      reqLen = n;
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && i++ < 100) @(posedge clk) #1;
      @(posedge clk) #1;
      reqValid = 1'b0;
      while (doneValid !== 1'b1 && opRejected !== 1'b1 && i++ < 20000) @(posedge clk) #1;
      if (i >= 20000) begin
         miscompares++;
         close_out();
      end
      rej = opRejected;
      cmp(u_mdl.log.size(), expQ.size());
      foreach (expQ[j]) cmp(u_mdl.log[j], expQ[j]);
      expQ.delete();
   endtask
   task automatic t_program;
      for (int j = 0; j < 8; j++) push(8'ha0 + 8'(j));
      wrValid = 1'b0;
      cmp(wrReady, 1'b0);
      e(2'd1, 8'h80);
      addr(ADR, 0, 4);
      for (int j = 0; j < 9; j++) e(2'd3, 8'ha0 + 8'(j));
      e(2'd1, 8'h10);
      fork
         begin
            push(8'ha8);
            wrValid = 1'b0;
         end
         run(4'h4, ADR, 13'd9);
      join
      cmp(rej, 1'b0);
   endtask
   task automatic t_read;
      e(2'd1, 8'h00);
      addr(ADR + 28'd1, 0, 4);
      e(2'd1, 8'h30);
      run(4'h0, ADR + 28'd1, 13'd3);
      cmp(rdQ.size(), 3);
      foreach (rdQ[j]) cmp(rdQ[j], 8'ha1 + 8'(j));
   endtask
   task automatic t_single;
      logic [3:0] ops[6] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'h6};
      foreach (ops[k]) begin
         case (ops[k])
            4'h1: begin
               e(2'd1, 8'h00);
               addr(ADR, 0, 4);
               e(2'd1, 8'h35);
            end
            4'h2: begin
               e(2'd1, 8'h90);
               addr(ADR, 0, 1);
            end
            4'h3: e(2'd1, 8'hff);
            4'h9: e(2'd1, 8'h70);
            4'ha: e(2'd1, 8'h7a);
            default: begin
               e(2'd1, 8'h60);
               addr(ADR, 2, 2);
               e(2'd1, 8'hd0);
            end
         endcase
         run(ops[k], ADR, 13'd0);
         cmp(rdQ.size(), ops[k] inside {4'h2, 4'h9, 4'ha});
         if (rdQ.size() == 1) cmp(rdQ[0], ops[k] == 4'h2 ? ID_B : ST_B);
      end
   endtask
   task automatic t_random;
      push(8'h5e);
      wrValid = 1'b0;
      e(2'd1, 8'h85);
      addr(ADR + 28'd5, 0, 2);
      e(2'd3, 8'h5e);
      run(4'h7, ADR + 28'd5, 13'd1);
      e(2'd1, 8'h05);
      addr(ADR + 28'd5, 0, 2);
      e(2'd1, 8'he0);
      run(4'h8, ADR + 28'd5, 13'd1);
      cmp(rdQ.size(), 1);
      cmp(rdQ[0], 8'h5e);
   endtask
   task automatic t_reject;
      run(4'hb, ADR, 13'd0);
      cmp(rej, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1 arst_n = 1'b1;
      @(posedge clk) #1;
      cmp(writeProtect_n, 1'b1);
      t_program();
      t_read();
      t_single();
      t_random();
      t_reject();
      close_out();
   end
endmodule
`default_nettype wire

// File: verif/ncap_nand_model.sv
// Behavioural flash device on the host pins.
// Assumes the bench resolves the bus and inverts rbLow into the ready line.
`timescale 1ns/1ns
`default_nettype none
module ncap_nand_model #(
   parameter BUSY_CYC = 20,
   parameter DLY      = 15,
   parameter ID_BYTE  = 8'h3c, // Arbitrary value
   parameter ST_BYTE  = 8'he0
) (
   // Clock for busy timing
   input  wire logic       clk,
   // Host pins
   input  wire logic [7:0] ioOut,
   input  wire logic       chipSelect_n,
   input  wire logic       cmdLatch,
   input  wire logic       addrLatch,
   input  wire logic       writeStrobe_n,
   input  wire logic       output_strobe_n,
   input  wire logic       writeProtect_n,
   // Device answers
   output var  logic [7:0] devData,
   output var  logic       devOe,
   output wire logic       rbLow
);
   logic [9:0]  log[$];
   logic [7:0]  pageReg[0:2111];
   logic [7:0]  cmd = 8'h00;
   logic [11:0] col = 12'h000;
   int          nAddr = 0;
   int          busyCnt = 0;
   initial begin
      devOe = 1'b0;
      devData = 8'h00;
      for (int i = 0; i < 2112; i++) pageReg[i] = 8'h5a;
   end
   assign rbLow = (busyCnt != 0);
   always @(posedge clk) if (busyCnt > 0) busyCnt--;
   always @(posedge writeStrobe_n) if (!chipSelect_n) begin
      if (cmdLatch) begin
         cmd = ioOut;
         nAddr = 0;
         log.push_back({2'd1, ioOut});
         if (ioOut inside {8'h30, 8'h35, 8'hff}) busyCnt = BUSY_CYC;
         if (ioOut inside {8'h10, 8'hd0}) busyCnt = writeProtect_n ? BUSY_CYC : 2;
      end else if (addrLatch) begin
         if (nAddr < 4) log.push_back({2'd2, ioOut});
         if (nAddr == 0) col[7:0] = ioOut;
         if (nAddr == 1) col[11:8] = ioOut[3:0];
         nAddr++;
      end else begin
         log.push_back({2'd3, ioOut});
         pageReg[col] = ioOut;
         col++;
      end
   end
   always @(negedge output_strobe_n) begin
      devOe = !chipSelect_n;
      devData = ~devData;
      #DLY;
      devData = cmd inside {8'h70, 8'h7a} ? ST_BYTE : cmd == 8'h90 ? ID_BYTE : pageReg[col];
      if (!(cmd inside {8'h70, 8'h7a, 8'h90})) col++;
   end
   always @(posedge output_strobe_n or posedge chipSelect_n) #DLY devOe = 1'b0;
endmodule
`default_nettype wire

// File: verilog/ncap_defines.vh
// Constants for the NAND command/address port host controller.
// Assumes a 100 MHz system clock; included by the controller files.
`ifndef NCAP_DEFINES_VH
`define NCAP_DEFINES_VH

// Command codes
`define NCAP_CMD_READ_SETUP     8'h00
`define NCAP_CMD_READ_CONFIRM   8'h30
`define NCAP_CMD_READ_COPY      8'h35
`define NCAP_CMD_READ_ID        8'h90
`define NCAP_CMD_RESET          8'hff
`define NCAP_CMD_PROG_SETUP     8'h80
`define NCAP_CMD_PROG_EXEC      8'h10
`define NCAP_CMD_COPY_PROG      8'h85
`define NCAP_CMD_ERASE_SETUP    8'h60
`define NCAP_CMD_ERASE_EXEC     8'hd0
`define NCAP_CMD_RAND_IN        8'h85
`define NCAP_CMD_RAND_OUT       8'h05
`define NCAP_CMD_RAND_OUT_CONF  8'he0
`define NCAP_CMD_STATUS         8'h70
`define NCAP_CMD_ECC_STATUS     8'h7a

// Operation selectors on the user port
`define NCAP_OP_W          4
`define NCAP_OP_READ       4'h0
`define NCAP_OP_READ_COPY  4'h1
`define NCAP_OP_READ_ID    4'h2
`define NCAP_OP_RESET      4'h3
`define NCAP_OP_PROGRAM    4'h4
`define NCAP_OP_COPY_PROG  4'h5
`define NCAP_OP_ERASE      4'h6
`define NCAP_OP_RAND_IN    4'h7
`define NCAP_OP_RAND_OUT   4'h8
`define NCAP_OP_STATUS     4'h9
`define NCAP_OP_ECC_STATUS 4'ha

// Address layout
`define NCAP_COL_W      12
`define NCAP_ROW_W      16
`define NCAP_ADDR_W     28
`define NCAP_COL_HI_MSB 11
`define NCAP_COL_HI_LSB 8
`define NCAP_ROW_LO_MSB 19
`define NCAP_ROW_LO_LSB 12
`define NCAP_ROW_HI_MSB 27
`define NCAP_ROW_HI_LSB 20
`define NCAP_NIB_ZERO   4'h0

// Page length, data plus spare
`define NCAP_PAGE_BYTES 13'h0840
`define NCAP_LEN_W      13

// Bus phase timing, ns and cycles at 10 ns; each count is the ns rounded up, access has one extra
`define NCAP_CLK_NS     10
`define NCAP_STROBE_NS  12
`define NCAP_ACCESS_NS  20
`define NCAP_ADL_NS     100
`define NCAP_WHR_NS     60
`define NCAP_WB_NS      100
`define NCAP_CYC_UP(t)  (((t) + `NCAP_CLK_NS - 1) / `NCAP_CLK_NS)
`define NCAP_CNT_W      4
`define NCAP_STROBE_CYC 4'd2
`define NCAP_ACCESS_CYC 4'd3
`define NCAP_ADL_CYC    4'd10
`define NCAP_WHR_CYC    4'd6
`define NCAP_WB_CYC     4'd10
`define NCAP_ONE_CNT    4'd1

// FIFO geometry
`define NCAP_FIFO_W     8
`define NCAP_FIFO_D     8

`endif

// File: verilog/ncap_fifo.v
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/1ns
`default_nettype none
module ncap_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             clk,
   input  wire             arst_n,
   // Fill side
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   // Drain side
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wrPtr_reg;
   reg [AW:0]      rdPtr_reg;
   reg             inReady_reg;
   wire [AW:0]     wrPtr_next;
   wire [AW:0]     rdPtr_next;
   wire            full;
   wire            empty;
   wire            push;
   wire            pop;

   assign empty    = (wrPtr_reg == rdPtr_reg);
   // Full flag kept in a flop so ready leaves straight from it
   assign full       = !inReady_reg;
   assign inReady    = inReady_reg;
   assign wrPtr_next = wrPtr_reg + {{AW{1'b0}}, push};
   assign rdPtr_next = rdPtr_reg + {{AW{1'b0}}, pop};
   assign outValid = !empty;
   assign outData  = mem[rdPtr_reg[AW-1:0]];
   assign push     = inValid && !full;
   assign pop      = outReady && !empty;

   always @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_reg <= {(AW+1){1'b0}};
         rdPtr_reg <= {(AW+1){1'b0}};
         inReady_reg <= 1'b1;
      end else begin
         inReady_reg <= (wrPtr_next[AW-1:0] != rdPtr_next[AW-1:0]) ||
                        (wrPtr_next[AW] == rdPtr_next[AW]);
         if (push) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: verilog/ncap_host.v
// Host controller for the NAND command/address/data port.
// Assumes inputs synchronous to clk; bus pins resolved outside.
`timescale 1ns/1ns
`default_nettype none
`include "ncap_defines.vh"
module ncap_host (
   // Clock and reset
   input  wire                    clk,
   input  wire                    arst_n,
   // Request port
   input  wire                    reqValid,
   output reg                     reqReady,
   input  wire [`NCAP_OP_W-1:0]   reqOp,
   input  wire [`NCAP_ADDR_W-1:0] reqAddr,
   input  wire [`NCAP_LEN_W-1:0]  reqLen,
   output reg                     doneValid,
   output reg                     opRejected,
   // Write data stream
   input  wire [7:0]              wrData,
   input  wire                    wrValid,
   output wire                    wrReady,
   // Read data stream
   output reg  [7:0]              rdData,
   output reg                     rdValid,
   input  wire                    rdReady,
   // NAND pins
   output reg  [7:0]              ioOut,
   output reg                     ioOe_n,
   input  wire [7:0]              ioIn,
   output reg                     chipSelect_n,
   output reg                     cmdLatch,
   output reg                     addrLatch,
   output reg                     writeStrobe_n,
   output reg                     output_strobe_n,
   output reg                     writeProtect_n,
   input  wire                    readyBusy
);
   localparam [10:0] S_IDLE = 11'h001, S_CMD1 = 11'h002, S_ADDR = 11'h004,
                     S_ADL = 11'h008, S_WDATA = 11'h010, S_CMD2 = 11'h020,
                     S_WB = 11'h040, S_BUSY = 11'h080, S_WHR = 11'h100,
                     S_RDATA = 11'h200, S_DONE = 11'h400;

   reg [10:0]              state_reg;
   reg [`NCAP_OP_W-1:0]    op_reg;
   reg [`NCAP_ADDR_W-1:0]  addr_reg;
   reg [`NCAP_LEN_W-1:0]   left_reg;
   reg [2:0]               addrIdx_reg;
   reg [2:0]               addrEnd_reg;
   reg [`NCAP_CNT_W-1:0]   cnt_reg;
   reg [1:0]               phase_reg;
   reg                     busyDev_reg;
   reg [7:0]               cmd1;
   reg [7:0]               cmd2;
   reg                     hasCmd2;
   reg                     hasData;
   reg                     isRead;
   reg                     needBusy;
   reg [2:0]               aStart;
   reg [2:0]               aEnd;
   reg [7:0]               addrByte;
   wire [7:0]              fifoData;
   wire                    fifoValid;
   reg                     fifoPop;

   ncap_fifo #(
      .WIDTH (`NCAP_FIFO_W),
      .DEPTH (`NCAP_FIFO_D),
      .AW    (3)
   ) u_wfifo (
      .clk      (clk),
      .arst_n   (arst_n),
      .inData   (wrData),
      .inValid  (wrValid),
      .inReady  (wrReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // Command decode per operation
   always @* begin
      cmd1 = `NCAP_CMD_STATUS;
      cmd2 = `NCAP_CMD_READ_CONFIRM;
      hasCmd2 = 1'b0;
      hasData = 1'b0;
      isRead = 1'b0;
      needBusy = 1'b0;
      aStart = 3'd0;
      aEnd = 3'd0;
      case (op_reg)
         `NCAP_OP_READ: begin
            cmd1 = `NCAP_CMD_READ_SETUP;
            cmd2 = `NCAP_CMD_READ_CONFIRM;
            hasCmd2 = 1'b1; isRead = 1'b1; needBusy = 1'b1;
            aEnd = 3'd4;
         end
         `NCAP_OP_READ_COPY: begin
            cmd1 = `NCAP_CMD_READ_SETUP;
            cmd2 = `NCAP_CMD_READ_COPY;
            hasCmd2 = 1'b1; needBusy = 1'b1; aEnd = 3'd4;
         end
         `NCAP_OP_PROGRAM: begin
            cmd1 = `NCAP_CMD_PROG_SETUP;
            cmd2 = `NCAP_CMD_PROG_EXEC;
            hasCmd2 = 1'b1; hasData = 1'b1; needBusy = 1'b1;
            aEnd = 3'd4;
         end
         `NCAP_OP_COPY_PROG: begin
            cmd1 = `NCAP_CMD_COPY_PROG;
            cmd2 = `NCAP_CMD_PROG_EXEC;
            hasCmd2 = 1'b1; hasData = 1'b1; needBusy = 1'b1;
            aEnd = 3'd4;
         end
         `NCAP_OP_ERASE: begin
            cmd1 = `NCAP_CMD_ERASE_SETUP;
            cmd2 = `NCAP_CMD_ERASE_EXEC;
            hasCmd2 = 1'b1; needBusy = 1'b1;
            aStart = 3'd2; aEnd = 3'd4;
         end
         `NCAP_OP_RAND_IN: begin
            cmd1 = `NCAP_CMD_RAND_IN;
            hasData = 1'b1; aEnd = 3'd2;
         end
         `NCAP_OP_RAND_OUT: begin
            cmd1 = `NCAP_CMD_RAND_OUT;
            cmd2 = `NCAP_CMD_RAND_OUT_CONF;
            hasCmd2 = 1'b1; isRead = 1'b1; aEnd = 3'd2;
         end
         `NCAP_OP_READ_ID: begin
            cmd1 = `NCAP_CMD_READ_ID;
            isRead = 1'b1; aEnd = 3'd1;
         end
         `NCAP_OP_RESET: begin
            cmd1 = `NCAP_CMD_RESET; needBusy = 1'b1;
         end
         `NCAP_OP_ECC_STATUS: begin
            cmd1 = `NCAP_CMD_ECC_STATUS; isRead = 1'b1;
         end
         default: begin
            cmd1 = `NCAP_CMD_STATUS; isRead = 1'b1;
         end
      endcase
   end

   // Address byte per cycle index
   always @* begin
      case (addrIdx_reg)
         3'd0: addrByte = addr_reg[7:0];
         3'd1: addrByte = {`NCAP_NIB_ZERO,
                           addr_reg[`NCAP_COL_HI_MSB:`NCAP_COL_HI_LSB]};
         3'd2: addrByte = addr_reg[`NCAP_ROW_LO_MSB:`NCAP_ROW_LO_LSB];
         default: addrByte = addr_reg[`NCAP_ROW_HI_MSB:`NCAP_ROW_HI_LSB];
      endcase
   end

   // Write phase: strobe low for STROBE_CYC, then high for STROBE_CYC
   wire phaseEnd = (cnt_reg == `NCAP_ONE_CNT);
   wire legalBusy = (reqOp == `NCAP_OP_RESET) || (reqOp == `NCAP_OP_STATUS);
   wire knownOp = (reqOp <= `NCAP_OP_ECC_STATUS);

   always @* begin
      fifoPop = (state_reg == S_WDATA) && (phase_reg == 2'd1) && phaseEnd;
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg       <= S_IDLE;
         op_reg          <= `NCAP_OP_STATUS;
         addr_reg        <= {`NCAP_ADDR_W{1'b0}};
         left_reg        <= {`NCAP_LEN_W{1'b0}};
         addrIdx_reg     <= 3'd0;
         addrEnd_reg     <= 3'd0;
         cnt_reg         <= `NCAP_ONE_CNT;
         phase_reg       <= 2'd0;
         busyDev_reg     <= 1'b0;
         reqReady        <= 1'b0;
         doneValid       <= 1'b0;
         opRejected      <= 1'b0;
         rdData          <= 8'h00;
         rdValid         <= 1'b0;
         ioOut           <= 8'h00;
         ioOe_n          <= 1'b1;
         chipSelect_n    <= 1'b1;
         cmdLatch        <= 1'b0;
         addrLatch       <= 1'b0;
         writeStrobe_n   <= 1'b1;
         output_strobe_n <= 1'b1;
         writeProtect_n  <= 1'b0;
      end else begin
         doneValid      <= 1'b0;
         opRejected     <= 1'b0;
         writeProtect_n <= 1'b1;
         if (rdValid && rdReady) begin
            rdValid <= 1'b0;
         end
         if (cnt_reg != `NCAP_ONE_CNT) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         case (state_reg)
            S_IDLE: begin
               reqReady <= 1'b1;
               ioOe_n   <= 1'b1;
               if (reqValid && reqReady) begin
                  reqReady <= 1'b0;
                  if (!knownOp || (busyDev_reg && !legalBusy)) begin
                     opRejected <= 1'b1;
                  end else begin
                     op_reg       <= reqOp;
                     addr_reg     <= reqAddr;
                     left_reg     <= reqLen;
                     chipSelect_n <= 1'b0;
                     phase_reg    <= 2'd0;
                     cnt_reg      <= `NCAP_STROBE_CYC;
                     state_reg    <= S_CMD1;
                  end
               end
            end
            S_CMD1, S_ADDR, S_WDATA, S_CMD2: begin
               if (phase_reg == 2'd0) begin
                  ioOe_n        <= 1'b0;
                  writeStrobe_n <= (state_reg == S_WDATA) && !fifoValid;
                  cmdLatch      <= (state_reg == S_CMD1) || (state_reg == S_CMD2);
                  addrLatch     <= (state_reg == S_ADDR);
                  if (state_reg == S_CMD1) begin
                     ioOut <= cmd1;
                  end else if (state_reg == S_CMD2) begin
                     ioOut <= cmd2;
                  end else if (state_reg == S_ADDR) begin
                     ioOut <= addrByte;
                  end else begin
                     ioOut <= fifoData;
                  end
                  if (state_reg != S_WDATA || fifoValid) begin
                     phase_reg <= 2'd2;
                     cnt_reg   <= `NCAP_STROBE_CYC;
                  end
               end else if (phase_reg == 2'd2) begin
                  if (phaseEnd) begin
                     writeStrobe_n <= 1'b1;
                     phase_reg     <= 2'd1;
                     cnt_reg       <= `NCAP_STROBE_CYC;
                  end
               end else if (phaseEnd) begin
                  cmdLatch  <= 1'b0;
                  addrLatch <= 1'b0;
                  phase_reg <= 2'd0;
                  cnt_reg   <= `NCAP_STROBE_CYC;
                  if (state_reg == S_CMD1) begin
                     if (busyDev_reg && op_reg == `NCAP_OP_STATUS) begin
                        cnt_reg   <= `NCAP_WHR_CYC;
                        state_reg <= S_WHR;
                     end else if (aEnd != aStart) begin
                        addrIdx_reg <= aStart;
                        addrEnd_reg <= aEnd;
                        state_reg   <= S_ADDR;
                     end else if (needBusy) begin
                        cnt_reg   <= `NCAP_WB_CYC;
                        state_reg <= S_WB;
                     end else begin
                        cnt_reg   <= `NCAP_WHR_CYC;
                        state_reg <= S_WHR;
                     end
                  end else if (state_reg == S_ADDR) begin
                     addrIdx_reg <= addrIdx_reg + 1'b1;
                     if (addrIdx_reg + 1'b1 == addrEnd_reg) begin
                        if (hasData) begin
                           cnt_reg   <= `NCAP_ADL_CYC;
                           state_reg <= S_ADL;
                        end else if (hasCmd2) begin
                           state_reg <= S_CMD2;
                        end else begin
                           cnt_reg   <= `NCAP_WHR_CYC;
                           state_reg <= S_WHR;
                        end
                     end
                  end else if (state_reg == S_WDATA) begin
                     left_reg <= left_reg - 1'b1;
                     if (left_reg == `NCAP_ONE_CNT || left_reg == 0) begin
                        state_reg <= hasCmd2 ? S_CMD2 : S_DONE;
                     end
                  end else if (needBusy) begin
                     cnt_reg   <= `NCAP_WB_CYC;
                     state_reg <= S_WB;
                  end else begin
                     cnt_reg   <= `NCAP_WHR_CYC;
                     state_reg <= S_WHR;
                  end
               end
            end
            S_ADL: begin
               ioOe_n <= 1'b1;
               if (phaseEnd) begin
                  state_reg <= (left_reg == 0) ? S_CMD2 : S_WDATA;
               end
            end
            S_WB: begin
               ioOe_n <= 1'b1;
               if (phaseEnd) begin
                  busyDev_reg <= 1'b1;
                  state_reg   <= S_BUSY;
               end
            end
            S_BUSY: begin
               chipSelect_n <= 1'b1;
               if (readyBusy) begin
                  busyDev_reg <= 1'b0;
                  if (isRead) begin
                     chipSelect_n <= 1'b0;
                     cnt_reg      <= `NCAP_WHR_CYC;
                     state_reg    <= S_WHR;
                  end else begin
                     state_reg <= S_DONE;
                  end
               end
            end
            S_WHR: begin
               ioOe_n <= 1'b1;
               phase_reg <= 2'd0;
               if (phaseEnd) begin
                  if (op_reg == `NCAP_OP_READ_ID || op_reg == `NCAP_OP_STATUS ||
                      op_reg == `NCAP_OP_ECC_STATUS) begin
                     left_reg  <= (left_reg == 0) ? `NCAP_LEN_W'd1 : left_reg;
                     state_reg <= S_RDATA;
                  end else begin
                     state_reg <= (left_reg == 0) ? S_DONE : S_RDATA;
                  end
               end
            end
            S_RDATA: begin
               if (phase_reg == 2'd0) begin
                  if (!rdValid || rdReady) begin
                     output_strobe_n <= 1'b0;
                     phase_reg       <= 2'd2;
                     cnt_reg         <= `NCAP_ACCESS_CYC;
                  end
               end else if (phase_reg == 2'd2) begin
                  if (phaseEnd) begin
                     rdData          <= ioIn;
                     rdValid         <= 1'b1;
                     output_strobe_n <= 1'b1;
                     left_reg        <= left_reg - 1'b1;
                     phase_reg       <= 2'd1;
                     cnt_reg         <= `NCAP_STROBE_CYC;
                  end
               end else if (phaseEnd) begin
                  phase_reg <= 2'd0;
                  if (left_reg == 0) begin
                     state_reg <= S_DONE;
                  end
               end
            end
            default: begin
               ioOe_n       <= 1'b1;
               chipSelect_n <= 1'b1;
               doneValid    <= 1'b1;
               state_reg    <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire
